// ===== src/reset_seq_defs.vh
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH

// Reset vector locations, user and monitor mode.
`define VEC_USER          16'hFFFE
`define VEC_MONITOR       16'hFEFE
// Watchdog service location.
`define WDOG_SERVICE_ADDR 16'hFFFF

// Register map of the plain register port.
`define ADDR_CAUSE        4'h0
`define ADDR_IRQ_CODE     4'h1
`define ADDR_CTRL         4'h2

// Cause register bit positions.
`define CAUSE_POR         7
`define CAUSE_PIN         6
`define CAUSE_WDOG        5
`define CAUSE_ILLEGAL_OPCODE_FLAG        4
`define CAUSE_ILLEGAL_ADDRESS_FLAG        3
`define CAUSE_LVI         1
`define CAUSE_RESET       8'h80

// Control register bit positions and reset value.
`define CTRL_STOP_EN      0
`define CTRL_SHORT_STOP_RECOVERY        1
`define CTRL_RESET        8'h01

// Timing in oscillator cycles.
`define PIN_MIN_CYC       7'd67
`define DRIVE_CYC         13'd32
`define TAIL_CYC          13'd32
`define STAB_CYC          13'd4096
`define RELEASE_CYC       13'd64
`define SHORT_STOP_CYC    13'd32

// Watchdog counter saturation value, in stabilisation counter overflows.
`define WDOG_TOP          8'hFF

`endif

// ===== src/reset_exception_sequencer.v
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "reset_seq_defs.vh"

module reset_exception_sequencer
(
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire        power_on_pulse,
    input  wire        low_voltage_in,
    input  wire        watchdog_async_in,
    input  wire        rst_pin_in,
    output wire        rst_pin_out,
    output wire        rst_pin_oe,
    input  wire        illegal_instr,
    input  wire        stop_instr,
    input  wire        stop_wake,
    input  wire        cpu_opcode_fetch,
    input  wire        cpu_access,
    input  wire        cpu_write,
    input  wire [15:0] cpu_addr,
    input  wire        addr_mapped,
    input  wire        monitor_mode,
    input  wire        break_state,
    input  wire        rst_test_high_voltage,
    input  wire        irq_test_high_voltage,
    input  wire [7:0]  irq_req,
    input  wire        irq_mask,
    input  wire        irq_serviced,
    output reg  [2:0]  irq_code,
    output reg         irq_pending,
    output wire        internal_reset,
    output reg  [15:0] reset_vector,
    output reg         internal_bus_clocks,
    output reg         clockgen_output,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata
);

    // Reset states hold the internal reset; run, stop and wake do not.
    localparam [2:0] ST_RUN   = 3'd0;
    localparam [2:0] ST_STAB  = 3'd1;
    localparam [2:0] ST_DRIVE = 3'd2;
    localparam [2:0] ST_TAIL  = 3'd3;
    localparam [2:0] ST_PIN   = 3'd4;
    localparam [2:0] ST_STOP  = 3'd5;
    localparam [2:0] ST_WAKE  = 3'd6;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [12:0] phase_reg;
    reg  [12:0] phase_next;
    reg  [12:0] stab_reg;
    reg  [12:0] stab_start;
    reg         stab_clear_all;
    reg         stab_clear_hi;
    reg         stab_ovf_reg;
    reg  [7:0]  wdog_reg;
    reg  [6:0]  pin_cnt_reg;
    reg         wdog_meta_reg;
    reg         wdog_sync_reg;
    reg  [7:0]  cause_reg;
    reg  [7:0]  ctrl_reg;
    reg         pin_flag_ok_reg;
    reg         long_reset_reg;
    reg         stop_hold_reg;

    // Highest numbered request wins; the code is a fixed index per source.
    function [2:0] prio_code;
        input [7:0] req;
        integer i;
        begin
            prio_code = 3'd0;
            for (i = 0; i < 8; i = i + 1)
            begin
                if (req[i])
                    prio_code = i[2:0];
            end
        end
    endfunction

    // Only the high-voltage test inputs can switch the watchdog off, so noise cannot.
    wire wdog_disable = ((rst_test_high_voltage | irq_test_high_voltage) & monitor_mode)
                      | (rst_test_high_voltage & break_state);
    wire wdog_fire   = wdog_sync_reg & ~wdog_disable;
    wire stop_illegal = stop_instr & ~ctrl_reg[`CTRL_STOP_EN];
    wire illegal_opcode_flag_fire   = illegal_instr | stop_illegal;
    wire illegal_address_flag_fire   = cpu_opcode_fetch & ~addr_mapped;
    wire short_src   = wdog_fire | illegal_opcode_flag_fire | illegal_address_flag_fire;
    wire long_src    = power_on_pulse | low_voltage_in;
    wire wdog_service = cpu_access & cpu_write & (cpu_addr == `WDOG_SERVICE_ADDR);
    wire in_reset    = (state_reg == ST_STAB) | (state_reg == ST_DRIVE)
                     | (state_reg == ST_TAIL) | (state_reg == ST_PIN);
    wire pin_low     = ~rst_pin_in;

    // The pin term halts everything at once, before the state machine has seen the pin.
    assign internal_reset = in_reset | pin_low;
    assign rst_pin_oe  = (state_reg == ST_STAB) | (state_reg == ST_DRIVE);
    assign rst_pin_out = 1'b0;

    // The watchdog overflow comes from another timing domain, so it is synchronised first.
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wdog_meta_reg <= 1'b0;
            wdog_sync_reg <= 1'b0;
        end
        else
        begin
            wdog_meta_reg <= watchdog_async_in;
            wdog_sync_reg <= wdog_meta_reg;
        end
    end

    // A long source always restarts the sequence at once; a short source does so in any state but ST_STAB.
    always @*
    begin
        state_next = state_reg;
        phase_next = phase_reg + 13'd1;
        stab_clear_all = 1'b0;
        if (long_src)
        begin
            state_next = ST_STAB;
            phase_next = 13'd0;
            stab_clear_all = 1'b1;
        end
        else if (short_src & (state_reg != ST_STAB))
        begin
            state_next = ST_DRIVE;
            phase_next = 13'd0;
            stab_clear_all = 1'b1;
        end
        else
        begin
            case (state_reg)
                ST_RUN:
                begin
                    phase_next = 13'd0;
                    if (pin_low)
                        state_next = ST_PIN;
                    else if (stop_instr & ctrl_reg[`CTRL_STOP_EN])
                    begin
                        state_next = ST_STOP;
                        stab_clear_all = 1'b1;
                    end
                end
                ST_STAB:
                    if (phase_reg == `STAB_CYC - 13'd1)
                    begin
                        state_next = ST_TAIL;
                        phase_next = 13'd0;
                    end
                ST_DRIVE:
                    if (phase_reg == `DRIVE_CYC - 13'd1)
                    begin
                        state_next = ST_TAIL;
                        phase_next = 13'd0;
                    end
                ST_TAIL:
                    if (phase_reg == (long_reset_reg ? `RELEASE_CYC : `TAIL_CYC) - 13'd1)
                    begin
                        state_next = ST_RUN;
                        phase_next = 13'd0;
                    end
                ST_PIN:
                begin
                    phase_next = 13'd0;
                    if (~pin_low)
                        state_next = ST_RUN;
                end
                ST_STOP:
                begin
                    phase_next = 13'd0;
                    if (stop_wake)
                        state_next = ST_WAKE;
                end
                ST_WAKE:
                    if (phase_reg == (ctrl_reg[`CTRL_SHORT_STOP_RECOVERY] ? `SHORT_STOP_CYC
                                                            : `STAB_CYC) - 13'd1)
                    begin
                        state_next = ST_RUN;
                        phase_next = 13'd0;
                    end
                default:
                begin
                    state_next = ST_RUN;
                    phase_next = 13'd0;
                end
            endcase
        end
        stab_clear_hi = wdog_service & ~stab_clear_all;
        stab_start = stab_clear_hi ? {9'd0, stab_reg[3:0]} : 13'd0;
    end

    // The kind of the last reset is kept: it picks the tail length and blocks the pin flag.
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg      <= ST_STAB;
            phase_reg      <= 13'd0;
            long_reset_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            if (long_src)
                long_reset_reg <= 1'b1;
            else if (short_src & (state_reg != ST_STAB))
                long_reset_reg <= 1'b0;
        end
    end

    // Counter on the falling edge; clears are requested from the rising-edge logic.
    always @(negedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stab_reg     <= 13'd0;
            stab_ovf_reg <= 1'b0;
        end
        else if (stab_clear_all | stab_clear_hi)
        begin
            stab_reg     <= stab_start;
            stab_ovf_reg <= 1'b0;
        end
        else
        begin
            stab_reg     <= stab_reg + 13'd1;
            stab_ovf_reg <= (stab_reg == 13'h1FFF);
        end
    end

    // Internal watchdog counter, prescaled by the stabilisation counter overflow.
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wdog_reg <= 8'h00;
        else if (in_reset | wdog_service | wdog_disable)
            wdog_reg <= 8'h00;
        else if (stab_ovf_reg & (wdog_reg != `WDOG_TOP))
            wdog_reg <= wdog_reg + 8'h01;
    end

    // Pin low time is counted only while the sequencer is not driving the pin itself.
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_cnt_reg     <= 7'd0;
            pin_flag_ok_reg <= 1'b0;
        end
        else if (pin_low & ~rst_pin_oe)
        begin
            if (pin_cnt_reg != `PIN_MIN_CYC)
                pin_cnt_reg <= pin_cnt_reg + 7'd1;
            pin_flag_ok_reg <= (pin_cnt_reg == `PIN_MIN_CYC - 7'd1) & ~long_src;
        end
        else
        begin
            pin_cnt_reg     <= 7'd0;
            pin_flag_ok_reg <= 1'b0;
        end
    end

    // Cause flags: hardware sets win over a software clear in the same cycle.
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cause_reg <= `CAUSE_RESET;
        else if (power_on_pulse)
            cause_reg <= `CAUSE_RESET;
        else
        begin
            if (reg_rd & (reg_addr == `ADDR_CAUSE))
                cause_reg <= 8'h00;
            if (low_voltage_in)
                cause_reg[`CAUSE_LVI] <= 1'b1;
            if (wdog_fire)
                cause_reg[`CAUSE_WDOG] <= 1'b1;
            if (illegal_opcode_flag_fire)
                cause_reg[`CAUSE_ILLEGAL_OPCODE_FLAG] <= 1'b1;
            if (illegal_address_flag_fire)
                cause_reg[`CAUSE_ILLEGAL_ADDRESS_FLAG] <= 1'b1;
            if (pin_flag_ok_reg & ~long_reset_reg)
                cause_reg[`CAUSE_PIN] <= 1'b1;
        end
    end

    // Control bits are ordinary registers, so every internal reset restores them too.
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl_reg <= `CTRL_RESET;
        else if (internal_reset)
            ctrl_reg <= `CTRL_RESET;
        else if (reg_wr & (reg_addr == `ADDR_CTRL))
            ctrl_reg <= reg_wdata & 8'h03;
    end

    // Latched interrupt holds until serviced or an internal reset clears it.
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_pending <= 1'b0;
            irq_code    <= 3'd0;
        end
        else if (internal_reset | irq_serviced)
            irq_pending <= 1'b0;
        else if (~irq_pending & ~irq_mask & (irq_req != 8'h00))
        begin
            irq_pending <= 1'b1;
            irq_code    <= prio_code(irq_req);
        end
    end

    // Read data stand for exactly one cycle after the strobe and are zero otherwise.
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reset_vector        <= `VEC_USER;
            internal_bus_clocks <= 1'b0;
            clockgen_output     <= 1'b0;
            reg_rdata           <= 8'h00;
        end
        else
        begin
            reset_vector <= monitor_mode ? `VEC_MONITOR : `VEC_USER;
            internal_bus_clocks <= (state_next == ST_RUN);
            clockgen_output <= 1'b1;
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    `ADDR_CAUSE:    reg_rdata <= cause_reg;
                    `ADDR_IRQ_CODE: reg_rdata <= {4'h0, irq_pending, irq_code};
                    `ADDR_CTRL:     reg_rdata <= ctrl_reg;
                    default:        reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule

// ===== testbench/reset_seq_monitor.sv
`timescale 1ns/1ps
`include "reset_seq_defs.vh"

module reset_seq_monitor
(
    input wire        sys_clk,
    input wire        sys_rst,
    input wire        rst_pin_in,
    input wire        rst_pin_out,
    input wire        rst_pin_oe,
    input wire        illegal_instr,
    input wire        cpu_opcode_fetch,
    input wire        cpu_access,
    input wire        addr_mapped,
    input wire        monitor_mode,
    input wire        irq_pending,
    input wire [2:0]  irq_code,
    input wire        irq_serviced,
    input wire        internal_reset,
    input wire [15:0] reset_vector,
    input wire        internal_bus_clocks,
    input wire        clockgen_output
);
    reg [12:0] oe_len;
    reg [12:0] tail_len;
    reg        drove_reg;

    // Lengths are counted in edges, so a sequence that restarts or stops early shows up.
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            oe_len   <= 13'h0000;
            tail_len <= 13'h0000;
            drove_reg <= 1'b0;
        end
        else
        begin
            oe_len   <= rst_pin_oe ? oe_len + 13'h0001 : 13'h0000;
            tail_len <= (internal_reset && rst_pin_in) ? tail_len + 13'h0001 : 13'h0000;
            drove_reg <= rst_pin_oe | (internal_reset & drove_reg);
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    pin_drive_low_a: assert property (rst_pin_oe |-> !rst_pin_out)
        else $error("reset pin enabled but not driven low");
    illegal_opcode_flag_drive_a: assert property (illegal_instr && !internal_reset |=> rst_pin_oe)
        else $error("illegal instruction did not start pin drive");
    illegal_address_flag_drive_a: assert property
        (cpu_opcode_fetch && cpu_access && !addr_mapped && !internal_reset |=> rst_pin_oe)
        else $error("unmapped fetch did not start pin drive");
    drive_length_a: assert property
        ($fell(rst_pin_oe) |-> (oe_len == 13'h0020 || oe_len > 13'h0FA0))
        else $error("pin drive length wrong");
    // A pin-only reset has no tail of its own, so only a sequence that drove the pin is timed.
    tail_length_a: assert property
        ($fell(internal_reset) && $past(rst_pin_in) && drove_reg
            |-> (tail_len == 13'h0020 || tail_len == 13'h0040))
        else $error("internal reset tail length wrong");
    vector_mode_a: assert property
        ($fell(internal_reset) |-> reset_vector == (monitor_mode ? `VEC_MONITOR : `VEC_USER))
        else $error("reset vector does not match mode");
    clocks_held_a: assert property (rst_pin_oe && $past(rst_pin_oe) |-> !internal_bus_clocks)
        else $error("bus clocks running during pin drive");
    clockgen_on_a: assert property (!internal_reset |-> clockgen_output)
        else $error("clock generator output off after reset");
    irq_hold_a: assert property
        (irq_pending && !irq_serviced && !internal_reset
            |=> internal_reset || (irq_pending && $stable(irq_code)))
        else $error("latched interrupt was pre-empted");
endmodule

bind reset_exception_sequencer reset_seq_monitor reset_seq_monitor_i
(
    .sys_clk, .sys_rst, .rst_pin_in, .rst_pin_out, .rst_pin_oe, .illegal_instr,
    .cpu_opcode_fetch, .cpu_access, .addr_mapped, .monitor_mode, .irq_pending, .irq_code,
    .irq_serviced, .internal_reset, .reset_vector, .internal_bus_clocks, .clockgen_output
);

// ===== testbench/reset_pin_partner.sv
`timescale 1ns/1ps

module reset_pin_partner
(
    input  wire pull_low,
    input  wire rst_pin_out,
    input  wire rst_pin_oe,
    output wire rst_pin_in
);
    // The pin has a pull-up; an outside chip may pull it low at any time, even while driven.
    assign rst_pin_in = (rst_pin_oe ? rst_pin_out : 1'b1) & !pull_low;
endmodule

// ===== testbench/test_system_reset_and_exception_sequencer.sv
`timescale 1ns/1ps
`include "reset_seq_defs.vh"

module test_system_reset_and_exception_sequencer;
    reg         sys_clk, sys_rst, power_on_pulse, low_voltage_in, watchdog_async_in;
    reg         illegal_instr, stop_instr, stop_wake, cpu_opcode_fetch, cpu_access, cpu_write;
    reg         addr_mapped, monitor_mode, break_state, rst_test_high_voltage;
    reg         irq_test_high_voltage, irq_mask, irq_serviced, reg_wr, reg_rd, pull_low, rd_d;
    reg  [15:0] cpu_addr;
    reg  [7:0]  irq_req, reg_wdata, r;
    reg  [3:0]  reg_addr;
    wire        rst_pin_in, rst_pin_out, rst_pin_oe, irq_pending, internal_reset;
    wire        internal_bus_clocks, clockgen_output;
    wire [2:0]  irq_code;
    wire [15:0] reset_vector;
    wire [7:0]  reg_rdata;
    integer     n_errors, tests_run;
    logic [7:0] exp_q[$];

    reset_exception_sequencer reset_exception_sequencer_i
    (
        .sys_clk, .sys_rst, .power_on_pulse, .low_voltage_in, .watchdog_async_in, .rst_pin_in,
        .rst_pin_out, .rst_pin_oe, .illegal_instr, .stop_instr, .stop_wake, .cpu_opcode_fetch,
        .cpu_access, .cpu_write, .cpu_addr, .addr_mapped, .monitor_mode, .break_state,
        .rst_test_high_voltage, .irq_test_high_voltage, .irq_req, .irq_mask, .irq_serviced,
        .irq_code, .irq_pending, .internal_reset, .reset_vector, .internal_bus_clocks,
        .clockgen_output, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
    );

    reset_pin_partner reset_pin_partner_i (.pull_low, .rst_pin_out, .rst_pin_oe, .rst_pin_in);

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask

    task rd(input logic [3:0] a, input logic [7:0] e);
    begin
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
    begin
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    end
    endtask

    // Counts falling edges so that the sample never races the rising edge that moves the pin.
    task seq(input integer drive, input integer tail);
        integer i;
    begin
        i = 0;
        @(negedge sys_clk);
        while (rst_pin_oe !== 1'b1 && i < 50)
        begin
            @(negedge sys_clk);
            i = i + 1;
        end
        i = 0;
        while (rst_pin_oe === 1'b1 && i < 5000)
        begin
            i = i + 1;
            @(negedge sys_clk);
        end
        chk(i, drive, "pin drive cycles");
        i = 0;
        while (internal_reset === 1'b1 && i < 500)
        begin
            i = i + 1;
            @(negedge sys_clk);
        end
        chk(i, tail, "internal reset tail");
    end
    endtask

    task conclude;
    begin
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    always @(posedge sys_clk)
    begin
        if (rd_d === 1'b1)
            chk(reg_rdata, exp_q.pop_front(), "register read");
        rd_d <= reg_rd;
    end

    initial
    begin
        #600000;
        n_errors = n_errors + 1;
        conclude;
    end

    initial
    begin : main
        integer i, k, hi;
        {power_on_pulse, low_voltage_in, watchdog_async_in, illegal_instr, stop_instr} = 5'h00;
        {stop_wake, cpu_opcode_fetch, cpu_access, cpu_write, monitor_mode, break_state} = 6'h00;
        {rst_test_high_voltage, irq_test_high_voltage, irq_mask, irq_serviced} = 4'h0;
        {reg_wr, reg_rd, pull_low, rd_d} = 4'h0;
        addr_mapped = 1'b1;
        cpu_addr = 16'h0000;
        irq_req = 8'h00;
        reg_wdata = 8'h00;
        reg_addr = 4'h0;
        n_errors = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        void'($urandom(38));
        cyc(16);
        sys_rst <= 1'b0;
        seq(4096, 64);
        chk(clockgen_output, 1'b1, "clock output");
        rd(`ADDR_CAUSE, `CAUSE_RESET);
        rd(`ADDR_CAUSE, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        rd(`ADDR_CTRL, `CTRL_RESET);
        @(posedge sys_clk);
        cpu_access  <= 1'b1;
        addr_mapped <= 1'b0;
        cpu_addr    <= 16'($urandom);
        @(posedge sys_clk);
        cpu_access  <= 1'b0;
        addr_mapped <= 1'b1;
        cyc(4);
        chk(rst_pin_oe, 1'b0, "data access to hole");
        $display("test power-on done");
        // Illegal opcode, illegal fetch and disabled stop, alternating monitor mode.
        for (k = 0; k < 3; k = k + 1)
        begin
            if (k == 2)
                wr(`ADDR_CTRL, 8'h00);
            @(posedge sys_clk);
            monitor_mode <= k[0];
            illegal_instr <= (k == 0);
            {cpu_access, cpu_opcode_fetch, addr_mapped} <= (k == 1) ? 3'h6 : 3'h1;
            stop_instr <= (k == 2);
            @(posedge sys_clk);
            {illegal_instr, stop_instr, cpu_access, cpu_opcode_fetch, addr_mapped} <= 5'h01;
            seq(32, 32);
            chk(reset_vector, k[0] ? `VEC_MONITOR : `VEC_USER, "vector");
            r = 8'h01 << ((k == 1) ? `CAUSE_ILLEGAL_ADDRESS_FLAG : `CAUSE_ILLEGAL_OPCODE_FLAG);
            rd(`ADDR_CAUSE, r);
            rd(`ADDR_CTRL, `CTRL_RESET);
        end
        monitor_mode <= 1'b0;
        $display("test internal sources done");
        pull_low <= 1'b1;
        cyc(70);
        chk(internal_reset, 1'b1, "pin held low");
        pull_low <= 1'b0;
        cyc(40);
        rd(`ADDR_CAUSE, 8'h01 << `CAUSE_PIN);
        pull_low <= 1'b1;
        cyc(20);
        pull_low <= 1'b0;
        cyc(40);
        rd(`ADDR_CAUSE, 8'h00);
        $display("test pin reset done");
        @(posedge sys_clk);
        {cpu_access, cpu_write, cpu_addr} <= {2'h3, `WDOG_SERVICE_ADDR};
        @(posedge sys_clk);
        {cpu_access, cpu_write, watchdog_async_in} <= 3'h1;
        // One overflow pulse; a held level would restart the pin drive on every edge.
        @(posedge sys_clk);
        watchdog_async_in <= 1'b0;
        seq(32, 32);
        rd(`ADDR_CAUSE, 8'h01 << `CAUSE_WDOG);
        @(posedge sys_clk);
        {monitor_mode, rst_test_high_voltage, watchdog_async_in} <= 3'h7;
        @(posedge sys_clk);
        watchdog_async_in <= 1'b0;
        cyc(4);
        chk(internal_reset, 1'b0, "watchdog disabled");
        {monitor_mode, rst_test_high_voltage} <= 2'h0;
        $display("test watchdog done");
        r = 8'($urandom_range(255, 1));
        hi = 0;
        for (i = 0; i < 8; i = i + 1)
            if (r[i])
                hi = i;
        irq_req <= r;
        cyc(4);
        chk(irq_pending, 1'b1, "irq pending");
        chk(irq_code, hi, "irq code");
        irq_req <= 8'hFF;
        cyc(4);
        chk(irq_code, hi, "irq code held");
        {irq_serviced, irq_req} <= 9'h100;
        @(posedge sys_clk);
        irq_serviced <= 1'b0;
        cyc(4);
        chk(irq_pending, 1'b0, "irq serviced");
        $display("test interrupts done");
        wr(`ADDR_CTRL, 8'h03);
        @(posedge sys_clk);
        stop_instr <= 1'b1;
        @(posedge sys_clk);
        stop_instr <= 1'b0;
        cyc(4);
        chk(internal_bus_clocks, 1'b0, "stopped clocks");
        stop_wake <= 1'b1;
        @(posedge sys_clk);
        stop_wake <= 1'b0;
        i = 0;
        while (internal_bus_clocks !== 1'b1 && i < 5000)
        begin
            @(negedge sys_clk);
            i = i + 1;
        end
        // Up to two edges of slack cover where the wake pulse lands against the counter.
        chk(i >= 32 && i <= 34, 1'b1, "short stop recovery");
        $display("test stop done");
        @(posedge sys_clk);
        low_voltage_in <= 1'b1;
        @(posedge sys_clk);
        low_voltage_in <= 1'b0;
        seq(4096, 64);
        @(posedge sys_clk);
        power_on_pulse <= 1'b1;
        @(posedge sys_clk);
        power_on_pulse <= 1'b0;
        seq(4096, 64);
        rd(`ADDR_CAUSE, `CAUSE_RESET);
        $display("test long resets done");
        cyc(8);
        conclude;
    end
endmodule
